// File: include/side_path_map.svh
`ifndef SIDE_PATH_MAP_SVH
`define SIDE_PATH_MAP_SVH

`define SP_CTRL_OFS 8'hE4
`define SP_SRC_OFS 8'hE5
`define SP_GAIN_OFS 8'hE6
`define SP_LROUTE_OFS 8'hE8
`define SP_RROUTE_OFS 8'hE9
`define SP_CDATA_OFS 8'hEA
`define SP_CIDX_OFS 8'hEB

`define SP_EN_BIT 7
`define SP_MUTE_BIT 6

`define SP_EN_RST 1'h0
`define SP_MUTE_RST 1'h1
`define SP_SRC_RST 2'h0
`define SP_GAIN_RST 5'h1C
`define SP_LMASK_RST 3'h1
`define SP_RMASK_RST 3'h2
`define SP_CDATA_RST 8'h00
`define SP_CIDX_RST 5'h00

`define SP_GAIN_FRAC 12

`endif

// File: include/side_path_pkg.sv
package side_path_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [1:0] src_sel_t;
  typedef logic [4:0] gain_code_t;
  typedef logic [2:0] route_mask_t;
  typedef logic [4:0] coef_idx_t;

endpackage

// File: include/side_fifo_if.sv
interface side_fifo_if #(
  parameter int W = 72
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;

  modport store (
    input wr_valid,
    input wr_data,
    input rd_ready,
    output wr_ready,
    output rd_valid,
    output rd_data
  );

  modport user (
    output wr_valid,
    output wr_data,
    output rd_ready,
    input wr_ready,
    input rd_valid,
    input rd_data
  );
endinterface

// File: rtl/side_sample_fifo.sv
module side_sample_fifo
  import side_path_pkg::*;
#(
  parameter int W = 72,
  parameter int DEPTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  side_fifo_if.store f
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
    logic wr_ready;
    logic rd_valid;
  } fifo_state_t;

  fifo_state_t s_ff;
  fifo_state_t nxt_s;
  logic push;
  logic pop;

  assign push = f.wr_valid && s_ff.wr_ready;
  assign pop = f.rd_ready && s_ff.rd_valid;
  assign f.wr_ready = s_ff.wr_ready;
  assign f.rd_valid = s_ff.rd_valid;
  assign f.rd_data = s_ff.mem[s_ff.rptr];

  // Full and empty are held in flops so both ready and valid leave the store registered.
  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.mem[s_ff.wptr] = f.wr_data;
      nxt_s.wptr = s_ff.wptr + 1'b1;
    end
    if (pop)
    begin
      nxt_s.rptr = s_ff.rptr + 1'b1;
    end
    case ({push, pop})
      2'b10: nxt_s.count = s_ff.count + 1'b1;
      2'b01: nxt_s.count = s_ff.count - 1'b1;
      default: nxt_s.count = s_ff.count;
    endcase
    nxt_s.wr_ready = (nxt_s.count != (PW+1)'(DEPTH));
    nxt_s.rd_valid = (nxt_s.count != '0);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_ff <= '0;
      s_ff.wr_ready <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  a_fifo_bound: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    s_ff.count <= (PW+1)'(DEPTH) && (s_ff.wr_ready == (s_ff.count != (PW+1)'(DEPTH))))
    else $error("FIFO count out of range or ready flag wrong.");

  c_fifo_full: cover property (@(posedge i_clk) disable iff (!i_arst_n) !s_ff.wr_ready);
endmodule

// File: rtl/sidetone_path_control.sv
`include "side_path_map.svh"

module sidetone_path_control
  import side_path_pkg::*;
#(
  parameter int W = 24,
  parameter int DEPTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  output logic [7:0] o_reg_rdata,
  input wire logic [3:0] i_coef_sel,
  output logic [15:0] o_coef_word,
  input wire logic i_left_out_filter_on,
  input wire logic i_right_out_filter_on,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [3:0][W-1:0] i_adc_samples,
  input wire logic [W-1:0] i_filt_left,
  input wire logic [W-1:0] i_filt_right,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_left_out_stream,
  output logic [W-1:0] o_right_out_stream
);
  localparam int FW = 3 * W;
  localparam int ACC = W + 8;

  // Linear gain per code in Q12, listed from code 31 down to code 0.
  localparam logic [31:0][15:0] GAIN_Q12 = {
    16'h1ADC, 16'h169A, 16'h1304, 16'h1000, 16'h0D76, 16'h0B54, 16'h0988, 16'h0805,
    16'h06BF, 16'h05AD, 16'h04C7, 16'h0405, 16'h0362, 16'h02D8, 16'h0265, 16'h0204,
    16'h01B2, 16'h016D, 16'h0133, 16'h0102, 16'h00D9, 16'h00B7, 16'h009A, 16'h0082,
    16'h006D, 16'h005C, 16'h004D, 16'h0041, 16'h0037, 16'h002E, 16'h0027, 16'h0021
  };

  typedef struct packed {
    logic en;
    logic mute;
    src_sel_t src;
    gain_code_t gain;
    route_mask_t lmask;
    route_mask_t rmask;
    reg_byte_t cdata;
    coef_idx_t cidx;
    logic [31:0][7:0] coef;
    reg_byte_t rdata;
    logic [15:0] coef_word;
    logic out_valid;
    logic [W-1:0] left;
    logic [W-1:0] right;
  } path_state_t;

  path_state_t s_ff;
  path_state_t nxt_s;

  side_fifo_if #(.W(FW)) fq ();

  side_sample_fifo #(
    .W(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .f(fq.store)
  );

  function automatic logic [W-1:0] sat(input logic signed [ACC-1:0] v);
    if (&v[ACC-1:W-1] || ~|v[ACC-1:W-1])
    begin
      return v[W-1:0];
    end
    else if (v[ACC-1])
    begin
      return {1'b1, {(W-1){1'b0}}};
    end
    else
    begin
      return {1'b0, {(W-1){1'b1}}};
    end
  endfunction

  logic [W-1:0] st_raw;
  logic [15:0] gain_lin;
  logic signed [W+16:0] st_prod;
  logic signed [W+4:0] st_shift;
  logic [W-1:0] st_sample;
  logic st_pass;
  logic pop;
  logic [W-1:0] q_st;
  logic [1:0][W-1:0] q_filt;
  logic [1:0][W-1:0] mix;
  logic [1:0] cross_on;
  logic [1:0][2:0] mask;

  // The sidetone is formed on entry so the queue carries finished samples.
  assign st_raw = i_adc_samples[s_ff.src];
  assign gain_lin = GAIN_Q12[s_ff.gain];
  assign st_prod = $signed(st_raw) * $signed({1'b0, gain_lin});
  assign st_shift = st_prod[W+16:`SP_GAIN_FRAC];
  assign st_pass = s_ff.en && !s_ff.mute;
  assign st_sample = st_pass ? sat(ACC'(st_shift)) : '0;

  assign fq.wr_valid = i_in_valid;
  assign fq.wr_data = {st_sample, i_filt_left, i_filt_right};
  assign o_in_ready = fq.wr_ready;

  assign pop = fq.rd_valid && (!s_ff.out_valid || i_out_ready);
  assign fq.rd_ready = pop;
  assign q_st = fq.rd_data[FW-1:2*W];
  assign q_filt[0] = fq.rd_data[2*W-1:W];
  assign q_filt[1] = fq.rd_data[W-1:0];
  assign mask[0] = s_ff.lmask;
  assign mask[1] = s_ff.rmask;
  assign cross_on[0] = i_left_out_filter_on;
  assign cross_on[1] = i_right_out_filter_on;

  // Stream 0 is left and 1 is right; the other side's filter needs that stream's enable.
  for (genvar g = 0; g < 2; g++)
  begin : g_mix
    logic signed [ACC-1:0] sum;
    always_comb
    begin
      sum = '0;
      if (mask[g][0] && (g == 0 || cross_on[g]))
      begin
        sum = sum + ACC'($signed(q_filt[0]));
      end
      if (mask[g][1] && (g == 1 || cross_on[g]))
      begin
        sum = sum + ACC'($signed(q_filt[1]));
      end
      if (mask[g][2])
      begin
        sum = sum + ACC'($signed(q_st));
      end
      mix[g] = sat(sum);
    end
  end

  always_comb
  begin
    nxt_s = s_ff;
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        `SP_CTRL_OFS:
        begin
          nxt_s.en = i_reg_wdata[`SP_EN_BIT];
          nxt_s.mute = i_reg_wdata[`SP_MUTE_BIT];
        end
        `SP_SRC_OFS: nxt_s.src = i_reg_wdata[1:0];
        `SP_GAIN_OFS: nxt_s.gain = i_reg_wdata[4:0];
        `SP_LROUTE_OFS: nxt_s.lmask = i_reg_wdata[2:0];
        `SP_RROUTE_OFS: nxt_s.rmask = i_reg_wdata[2:0];
        `SP_CDATA_OFS: nxt_s.cdata = i_reg_wdata;
        `SP_CIDX_OFS:
        begin
          nxt_s.cidx = i_reg_wdata[4:0];
          nxt_s.coef[i_reg_wdata[4:0]] = s_ff.cdata;
        end
        default: nxt_s.cidx = s_ff.cidx;
      endcase
    end
    case (i_reg_addr)
      `SP_CTRL_OFS: nxt_s.rdata = {s_ff.en, s_ff.mute, 6'h00};
      `SP_SRC_OFS: nxt_s.rdata = {6'h00, s_ff.src};
      `SP_GAIN_OFS: nxt_s.rdata = {3'h0, s_ff.gain};
      `SP_LROUTE_OFS: nxt_s.rdata = {5'h00, s_ff.lmask};
      `SP_RROUTE_OFS: nxt_s.rdata = {5'h00, s_ff.rmask};
      `SP_CDATA_OFS: nxt_s.rdata = s_ff.cdata;
      `SP_CIDX_OFS: nxt_s.rdata = {3'h0, s_ff.cidx};
      default: nxt_s.rdata = 8'h00;
    endcase
    // Coefficient k is the byte pair at indices 2k and 2k+1.
    nxt_s.coef_word = {s_ff.coef[{i_coef_sel, 1'b1}], s_ff.coef[{i_coef_sel, 1'b0}]};
    if (pop)
    begin
      nxt_s.out_valid = 1'b1;
      nxt_s.left = mix[0];
      nxt_s.right = mix[1];
    end
    else if (i_out_ready)
    begin
      nxt_s.out_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_ff <= '0;
      s_ff.en <= `SP_EN_RST;
      s_ff.mute <= `SP_MUTE_RST;
      s_ff.src <= `SP_SRC_RST;
      s_ff.gain <= `SP_GAIN_RST;
      s_ff.lmask <= `SP_LMASK_RST;
      s_ff.rmask <= `SP_RMASK_RST;
      s_ff.cdata <= `SP_CDATA_RST;
      s_ff.cidx <= `SP_CIDX_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign o_reg_rdata = s_ff.rdata;
  assign o_coef_word = s_ff.coef_word;
  assign o_out_valid = s_ff.out_valid;
  assign o_left_out_stream = s_ff.left;
  assign o_right_out_stream = s_ff.right;

  default clocking dflt_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_disabled_silent: assert property (
    fq.wr_valid && !s_ff.en |-> fq.wr_data[FW-1:2*W] == '0)
    else $error("Sidetone sample not zero while path disabled.");

  a_muted_silent: assert property (
    fq.wr_valid && s_ff.mute |-> fq.wr_data[FW-1:2*W] == '0)
    else $error("Sidetone sample not zero while muted.");

  a_unity_source: assert property (
    fq.wr_valid && s_ff.en && !s_ff.mute && s_ff.gain == 5'h1C
    |-> fq.wr_data[FW-1:2*W] == i_adc_samples[s_ff.src])
    else $error("Unity gain sidetone differs from the selected converter.");

  a_ctrl_write: assert property (
    i_reg_wr && i_reg_addr == `SP_CTRL_OFS
    |=> s_ff.en == $past(i_reg_wdata[7]) && s_ff.mute == $past(i_reg_wdata[6])
        ##1 (s_ff.rdata[7:6] == $past({s_ff.en, s_ff.mute}) || $past(i_reg_addr) != `SP_CTRL_OFS))
    else $error("Control write or readback mismatch.");

  a_index_copy: assert property (
    i_reg_wr && i_reg_addr == `SP_CIDX_OFS
    |=> s_ff.coef[$past(i_reg_wdata[4:0])] == $past(s_ff.cdata))
    else $error("Index write did not copy the held data byte.");

  a_coef_pairing: assert property (
    ##1 o_coef_word == {$past(s_ff.coef[{i_coef_sel, 1'b1}]), $past(s_ff.coef[{i_coef_sel, 1'b0}])})
    else $error("Coefficient word not formed from odd high and even low byte.");

  a_left_side_only: assert property (
    pop && s_ff.lmask == 3'h4 |=> o_left_out_stream == $past(q_st) && o_out_valid)
    else $error("Left stream with sidetone only does not equal the sidetone.");

  a_left_cross_gate: assert property (
    pop && s_ff.lmask == 3'h2
    |=> o_left_out_stream == ($past(i_left_out_filter_on) ? $past(q_filt[1]) : '0))
    else $error("Right filter reached left stream against its enable.");

  a_right_cross_gate: assert property (
    pop && s_ff.rmask == 3'h1
    |=> o_right_out_stream == ($past(i_right_out_filter_on) ? $past(q_filt[0]) : '0))
    else $error("Left filter reached right stream against its enable.");

  a_empty_mask_zero: assert property (
    pop && s_ff.rmask == 3'h0 |=> o_right_out_stream == '0)
    else $error("Right stream not zero with no source selected.");

  a_output_hold: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_left_out_stream)
                                    && $stable(o_right_out_stream))
    else $error("Output stream changed while stalled.");

  c_sidetone_mixed: cover property (pop && st_pass && s_ff.lmask[2] && s_ff.rmask[2]);
  c_coef_loaded: cover property (i_reg_wr && i_reg_addr == `SP_CDATA_OFS
                                 ##1 i_reg_wr && i_reg_addr == `SP_CIDX_OFS);
  c_backpressure: cover property (i_in_valid && !o_in_ready);
endmodule

// File: bench/side_sink_model.sv
// Playback sink: accepts output pairs unless told to stall, keeps the last pair.
module side_sink_model #(
  parameter int W = 24
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  input wire logic [W-1:0] i_left,
  input wire logic [W-1:0] i_right,
  input wire logic i_stall,
  output logic o_ready,
  output logic [W-1:0] o_got_left,
  output logic [W-1:0] o_got_right,
  output int o_got_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_ready = !i_stall;
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      o_got_n <= 0;
      o_got_left <= '0;
      o_got_right <= '0;
    end
    else if (i_valid && o_ready)
    begin
      o_got_n <= o_got_n + 1;
      o_got_left <= i_left;
      o_got_right <= i_right;
    end
endmodule

// File: bench/sidetone_path_control_bench.sv
module sidetone_path_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import side_path_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic [7:0] rdata;
  logic [3:0] coef_sel = 4'h0;
  logic [15:0] coef_word;
  logic lon = 1'b0;
  logic ron = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [3:0][23:0] adc = {24'h000190, 24'hFFFED4, 24'h0000C8, 24'h001000};
  logic [23:0] fl = 24'h0003E8;
  logic [23:0] fr = 24'h004E20;
  logic out_valid;
  logic out_ready;
  logic stall = 1'b0;
  logic [23:0] left_s;
  logic [23:0] right_s;
  logic [23:0] got_l;
  logic [23:0] got_r;
  int got_n;
  int failures = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  sidetone_path_control #(.W(24), .DEPTH(8)) dut_u (.i_clk(clk), .i_arst_n(arst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata),
    .i_coef_sel(coef_sel), .o_coef_word(coef_word), .i_left_out_filter_on(lon),
    .i_right_out_filter_on(ron), .i_in_valid(in_valid), .o_in_ready(in_ready),
    .i_adc_samples(adc), .i_filt_left(fl), .i_filt_right(fr), .o_out_valid(out_valid),
    .i_out_ready(out_ready), .o_left_out_stream(left_s), .o_right_out_stream(right_s));

  side_sink_model #(.W(24)) sink_u (.i_clk(clk), .i_arst_n(arst_n), .i_valid(out_valid),
    .i_left(left_s), .i_right(right_s), .i_stall(stall), .o_ready(out_ready),
    .o_got_left(got_l), .o_got_right(got_r), .o_got_n(got_n));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    repeat (3) @(negedge clk);
    chk("register", {24'h0, rdata}, {24'h0, exp});
  endtask

  task automatic send;
    int k;
    k = 0;
    @(negedge clk);
    in_valid = 1'b1;
    while (in_ready !== 1'b1 && k < 50)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask

  task automatic mix(input logic [7:0] ctrl, input logic [7:0] sel, input logic [7:0] gain,
    input logic [7:0] lm, input logic [7:0] rm, input logic l_on, input logic r_on,
    input logic [23:0] el, input logic [23:0] er);
    int n0;
    int k;
    wr_reg(8'hE4, ctrl);
    wr_reg(8'hE5, sel);
    wr_reg(8'hE6, gain);
    wr_reg(8'hE8, lm);
    wr_reg(8'hE9, rm);
    lon = l_on;
    ron = r_on;
    n0 = got_n;
    send;
    k = 0;
    while (got_n == n0 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk("outputs taken", 32'(got_n - n0), 32'h1);
    chk("left stream", {8'h0, got_l}, {8'h0, el});
    chk("right stream", {8'h0, got_r}, {8'h0, er});
  endtask

  task automatic t_reset;
    rd_chk(8'hE4, 8'h40);
    rd_chk(8'hE5, 8'h00);
    rd_chk(8'hE6, 8'h1C);
    rd_chk(8'hE8, 8'h01);
    rd_chk(8'hE9, 8'h02);
    rd_chk(8'hEA, 8'h00);
    rd_chk(8'hEB, 8'h00);
    rd_chk(8'hE7, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_route;
    mix(8'h40, 8'h0, 8'h1C, 8'h1, 8'h2, 1'b0, 1'b0, fl, fr);
    mix(8'h40, 8'h0, 8'h1C, 8'h4, 8'h4, 1'b0, 1'b0, 24'h0, 24'h0);
    mix(8'hC0, 8'h0, 8'h1C, 8'h4, 8'h4, 1'b0, 1'b0, 24'h0, 24'h0);
    mix(8'h00, 8'h0, 8'h1C, 8'h4, 8'h4, 1'b0, 1'b0, 24'h0, 24'h0);
    mix(8'h80, 8'h0, 8'h1C, 8'h0, 8'h4, 1'b0, 1'b0, 24'h0, adc[0]);
    $display("test routing done");
  endtask

  task automatic t_select;
    for (int s = 0; s < 4; s++)
      mix(8'h80, 8'(s), 8'h1C, 8'h4, 8'h6, 1'b0, 1'b0, adc[s], adc[s] + fr);
    mix(8'h80, 8'h0, 8'h00, 8'h4, 8'h4, 1'b0, 1'b0, 24'h21, 24'h21);
    mix(8'h80, 8'h0, 8'h1F, 8'h4, 8'h4, 1'b0, 1'b0, 24'h1ADC, 24'h1ADC);
    $display("test select and gain done");
  endtask

  task automatic t_gate;
    mix(8'h00, 8'h0, 8'h1C, 8'h3, 8'h3, 1'b0, 1'b0, fl, fr);
    mix(8'h00, 8'h0, 8'h1C, 8'h3, 8'h3, 1'b1, 1'b1, fl + fr, fl + fr);
    mix(8'h00, 8'h0, 8'h1C, 8'h2, 8'h1, 1'b1, 1'b0, fr, 24'h0);
    mix(8'h00, 8'h0, 8'h1C, 8'h2, 8'h1, 1'b0, 1'b1, 24'h0, fl);
    $display("test filter gating done");
  endtask

  task automatic t_coef;
    wr_reg(8'hEA, 8'h34);
    wr_reg(8'hEB, 8'h05);
    wr_reg(8'hEA, 8'h12);
    wr_reg(8'hEB, 8'h04);
    coef_sel = 4'h2;
    repeat (2) @(negedge clk);
    chk("coefficient", {16'h0, coef_word}, 32'h3412);
    rd_chk(8'hEA, 8'h12);
    rd_chk(8'hEB, 8'h04);
    $display("test coefficient load done");
  endtask

  task automatic t_fifo;
    int k;
    int n0;
    mix(8'h00, 8'h0, 8'h1C, 8'h1, 8'h0, 1'b0, 1'b0, fl, 24'h0);
    n0 = got_n;
    stall = 1'b1;
    k = 0;
    in_valid = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      fl = 24'(k);
      if (in_ready === 1'b1)
        k++;
      @(negedge clk);
    end
    in_valid = 1'b0;
    chk("sets taken", 32'(k), 32'd9);
    stall = 1'b0;
    for (int i = 0; i < 40 && got_n < n0 + 9; i++)
      @(negedge clk);
    chk("sets drained", 32'(got_n - n0), 32'd9);
    chk("last set", {8'h0, got_l}, 32'h8);
    $display("test buffering done");
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report;
  end

  initial
  begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    t_reset;
    t_route;
    t_select;
    t_gate;
    t_coef;
    t_fifo;
    final_report;
  end
endmodule
